//--- pmicirq_defs.svh
// Constants for the interrupt aggregator and push-button block.
`ifndef PMICIRQ_DEFS_SVH
`define PMICIRQ_DEFS_SVH

// Group indices of the second-level registers.
`define PMICIRQ_G_STATUS1 0
`define PMICIRQ_G_THERMAL 1
`define PMICIRQ_G_MODE 2
`define PMICIRQ_G_SW_ILIM 3
`define PMICIRQ_G_LDO_ILIM 4
`define PMICIRQ_G_SW_UV 5
`define PMICIRQ_G_SW_OV 6
`define PMICIRQ_G_LDO_UV 7
`define PMICIRQ_G_LDO_OV 8
`define PMICIRQ_G_BUTTON 9
`define PMICIRQ_NGRP 10

// Register map: group g has latch at 3g, mask at 3g+1, live at 3g+2.
`define PMICIRQ_GRP_STRIDE 3
`define PMICIRQ_OFF_LATCH 0
`define PMICIRQ_OFF_MASK 1
`define PMICIRQ_OFF_LIVE 2
`define PMICIRQ_OFF_SUMMARY 8'h1E
`define PMICIRQ_OFF_CTRL 8'h1F

// Implemented bits per group, group 9 in the top byte.
`define PMICIRQ_VALID 80'hFF_0F_0F_7F_7F_0F_7F_7F_FF_FF
`define PMICIRQ_LIVE_VALID 80'h81_0F_0F_7F_7F_0F_7F_00_FF_07
`define PMICIRQ_MASK_RST 8'hFF

// Summary bit positions.
`define PMICIRQ_SUM_STATUS1 0
`define PMICIRQ_SUM_STATUS2 1
`define PMICIRQ_SUM_MODE 2
`define PMICIRQ_SUM_ILIM 3
`define PMICIRQ_SUM_UV 4
`define PMICIRQ_SUM_OV 5
`define PMICIRQ_SUM_BUTTON 6
`define PMICIRQ_SUM_EWARN 7

// Field positions inside groups and the control register.
`define PMICIRQ_BIT_EXT_IRQ 2
`define PMICIRQ_BIT_PRESS 0
`define PMICIRQ_BIT_RELEASE 1
`define PMICIRQ_BIT_HOLD1 2
`define PMICIRQ_BIT_BGMON 7
`define PMICIRQ_BIT_LIVE_BUTTON 0
`define PMICIRQ_CTRL_RST_EN 0
`define PMICIRQ_CTRL_DBNC_LO 1
`define PMICIRQ_CTRL_DELAY_LO 3
`define PMICIRQ_CTRL_EDGE 5

// Timing figures in their own units.
`define PMICIRQ_CLK_MHZ 100
`define PMICIRQ_TICK_MS 1
`define PMICIRQ_RESTART_US 30
`define PMICIRQ_DBNC_FAST_MS 32
`define PMICIRQ_DBNC_MID_MS 125
`define PMICIRQ_DBNC_SLOW_MS 750
`define PMICIRQ_HOLD_1S_MS 1000
`define PMICIRQ_HOLD_2S_MS 2000
`define PMICIRQ_HOLD_3S_MS 3000
`define PMICIRQ_HOLD_4S_MS 4000
`define PMICIRQ_HOLD_8S_MS 8000
`define PMICIRQ_LP_2S_MS 2000
`define PMICIRQ_LP_4S_MS 4000
`define PMICIRQ_LP_8S_MS 8000
`define PMICIRQ_LP_16S_MS 16000
`define PMICIRQ_MS_W 14
`define PMICIRQ_DBC_W 10

`endif

//--- pmicirq_pkg.sv
// Types shared by the interrupt aggregator and its environment.
package pmicirq_pkg;

	// One byte per second-level group.
	typedef logic [9:0][7:0] pmicirq_grp_vec_t;

	// Event pulses and live conditions from the monitors, same clock.
	typedef struct packed {
		pmicirq_grp_vec_t evt;
		pmicirq_grp_vec_t live;
	} pmicirq_evt_t;

	// Register access from the serial interface engine.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmicirq_reg_req_t;

	// Long-press restart sequencer.
	typedef enum logic [0:0] {
		LP_IDLE,
		LP_DISCHARGE
	} pmicirq_lp_state_t;

endpackage

//--- pmicirq_top.sv
// Two-level interrupt aggregation and power button logic.
// Notes on behaviour
// (R1) Latch sets on event, clears on write-one.
// (R2) Mask one hides latch, zero asserts output.
// (R3) Live bits mirror the latch source conditions.
// (R4) Output is OR of unmasked latches.
// (R5) Summary bit set by unmasked group latches.
// (R6) Summary bit clears itself with its latches.
// (R7) Summary bits map groups zero to seven; the code folds groups 0 to 9 into bits 0 to 6, and bit 7 is the early warning.
// (R8) Early warning sets summary bit directly.
// (R9) Output held while any summary bit set.
// (R10) Group bits identify converters and linear regulators.
// (R11) Level mode: high pin allows power-on.
// (R12) Edge mode: push button pulls pin low.
// (R13) Live button bit is inverted pin level.
// (R14) Debounce 32/125/750 ms falling, 32 rising.
// (R15) Debounce setting resets from configuration field.
// (R16) Debounced press starts power-on and interrupt.
// (R17) Press and release latched in system-on.
// (R18) Hold latches after 1,2,3,4,8 seconds.
// (R19) Long press reset: down, 30 us, up.
// (R20) Without reset enable, long press turns off.
// (R21) Long-press delay 2/4/8/16 s, configurable default.
// (R22) External input falling edge sets its latch.
// (R23) Bypassed faults still latch and interrupt.
// (R24) Latches reset to zero; inputs synchronised.
// (R25) Host reads summary, then group, clears.
`timescale 1ns/1ps
`default_nettype none
`include "pmicirq_defs.svh"

module pmicirq_top #(
	parameter int TICK_CYCLES = `PMICIRQ_CLK_MHZ * 1000 * `PMICIRQ_TICK_MS,
	parameter logic [7:0] MASK_RST = `PMICIRQ_MASK_RST
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port from the serial interface engine.
	input wire pmicirq_pkg::pmicirq_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	// Monitor events and system state.
	input wire pmicirq_pkg::pmicirq_evt_t evt_i,
	input wire logic early_warning_i,
	input wire logic system_on_i,
	// Pins.
	input wire logic power_button_in_i,
	input wire logic external_irq_in_n_i,
	output logic irq_out_n_o,
	output logic irq_out_n_oe_n_o,
	// One-time-programmable defaults.
	input wire logic button_edge_mode_cfg_i,
	input wire logic [1:0] button_debounce_default_i,
	input wire logic [1:0] long_press_delay_default_i,
	input wire logic long_press_reset_default_i,
	// Power state requests.
	output logic power_on_event_o,
	output logic turn_off_event_o,
	output logic power_down_req_o,
	output logic power_up_req_o
);

	localparam int NG = `PMICIRQ_NGRP;
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int RESTART_CYC = `PMICIRQ_RESTART_US * `PMICIRQ_CLK_MHZ;
	localparam int RW = $clog2(RESTART_CYC + 1);
	localparam logic [79:0] VALID = `PMICIRQ_VALID;
	localparam logic [79:0] LIVE_VALID = `PMICIRQ_LIVE_VALID;

	logic btn_s1_r, btn_s2_r, ext_s1_r, ext_s2_r, ext_d_r;
	logic cfg_loaded_r, edge_mode_r, rst_en_r;
	logic [1:0] dbnc_sel_r, delay_sel_r;
	logic [TW-1:0] tick_cnt_r;
	logic tick_r;
	logic db_lvl_r, db_fall_r, db_rise_r;
	logic [`PMICIRQ_DBC_W-1:0] dbc_r, dbc_thr;
	logic [`PMICIRQ_MS_W-1:0] hold_ms_r, lp_thr;
	logic [4:0] hold_hit;
	logic lp_hit;
	pmicirq_pkg::pmicirq_lp_state_t lp_state_r;
	logic [RW-1:0] rs_cnt_r;
	pmicirq_pkg::pmicirq_grp_vec_t lat_r, mask_r, ev_all, live_all, clr;
	logic [NG-1:0] pend;
	logic ewarn_r;
	logic [7:0] sum_nxt, sum_r, rd_nxt, ctrl_rd;

	// Two-stage synchronisers; pins idle high, so reset to one.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			btn_s1_r <= 1'b1;
			btn_s2_r <= 1'b1;
			ext_s1_r <= 1'b1;
			ext_s2_r <= 1'b1;
			ext_d_r <= 1'b1;
		end else begin
			btn_s1_r <= power_button_in_i; // R24
			btn_s2_r <= btn_s1_r;
			ext_s1_r <= external_irq_in_n_i; // R24
			ext_s2_r <= ext_s1_r;
			ext_d_r <= ext_s2_r;
		end
	end

	// Straps are sampled after reset release, and again on a restart.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_loaded_r <= 1'b0;
			edge_mode_r <= 1'b0;
			rst_en_r <= 1'b0;
			dbnc_sel_r <= 2'h0;
			delay_sel_r <= 2'h0;
		end else if (!cfg_loaded_r || power_up_req_o) begin
			cfg_loaded_r <= 1'b1;
			edge_mode_r <= button_edge_mode_cfg_i;
			rst_en_r <= long_press_reset_default_i;
			dbnc_sel_r <= button_debounce_default_i; // R15
			delay_sel_r <= long_press_delay_default_i; // R21
		end else if (reg_req_i.wr && reg_req_i.addr == `PMICIRQ_OFF_CTRL) begin
			rst_en_r <= reg_req_i.wdata[`PMICIRQ_CTRL_RST_EN];
			dbnc_sel_r <= reg_req_i.wdata[`PMICIRQ_CTRL_DBNC_LO +: 2];
			delay_sel_r <= reg_req_i.wdata[`PMICIRQ_CTRL_DELAY_LO +: 2];
		end
	end

	// Millisecond time base for debounce and hold timers.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// Falling edges use the selected time, rising edges the short one.
	always_comb begin
		dbc_thr = `PMICIRQ_DBC_W'(`PMICIRQ_DBNC_FAST_MS); // R14
		if (btn_s2_r == 1'b0 && db_lvl_r == 1'b1) begin
			unique case (dbnc_sel_r)
				2'h2: dbc_thr = `PMICIRQ_DBC_W'(`PMICIRQ_DBNC_MID_MS);
				2'h3: dbc_thr = `PMICIRQ_DBC_W'(`PMICIRQ_DBNC_SLOW_MS);
				default: dbc_thr = `PMICIRQ_DBC_W'(`PMICIRQ_DBNC_FAST_MS);
			endcase
		end
	end

	// Debouncer: a level must differ for the whole time before it counts.
	// The count restarts on any bounce back to the settled level.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			db_lvl_r <= 1'b1;
			dbc_r <= '0;
			db_fall_r <= 1'b0;
			db_rise_r <= 1'b0;
		end else begin
			db_fall_r <= 1'b0;
			db_rise_r <= 1'b0;
			if (btn_s2_r == db_lvl_r) begin
				dbc_r <= '0;
			end else if (tick_r) begin
				if (dbc_r == dbc_thr - 1'b1) begin
					dbc_r <= '0;
					db_lvl_r <= btn_s2_r; // R14
					db_fall_r <= ~btn_s2_r;
					db_rise_r <= btn_s2_r;
				end else begin
					dbc_r <= dbc_r + 1'b1;
				end
			end
		end
	end

	// Hold time since the debounced press, saturating at full scale.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_ms_r <= '0;
		end else if (db_lvl_r) begin
			hold_ms_r <= '0;
		end else if (tick_r && hold_ms_r != '1) begin
			hold_ms_r <= hold_ms_r + 1'b1;
		end
	end

	// Hold events fire on the tick that takes the count past each mark.
	always_comb begin
		hold_hit[0] = hold_ms_r == `PMICIRQ_MS_W'(`PMICIRQ_HOLD_1S_MS);
		hold_hit[1] = hold_ms_r == `PMICIRQ_MS_W'(`PMICIRQ_HOLD_2S_MS);
		hold_hit[2] = hold_ms_r == `PMICIRQ_MS_W'(`PMICIRQ_HOLD_3S_MS);
		hold_hit[3] = hold_ms_r == `PMICIRQ_MS_W'(`PMICIRQ_HOLD_4S_MS);
		hold_hit[4] = hold_ms_r == `PMICIRQ_MS_W'(`PMICIRQ_HOLD_8S_MS);
		hold_hit = hold_hit & {5{tick_r & ~db_lvl_r}}; // R18
		unique case (delay_sel_r)
			2'h0: lp_thr = `PMICIRQ_MS_W'(`PMICIRQ_LP_2S_MS); // R21
			2'h1: lp_thr = `PMICIRQ_MS_W'(`PMICIRQ_LP_4S_MS);
			2'h2: lp_thr = `PMICIRQ_MS_W'(`PMICIRQ_LP_8S_MS);
			2'h3: lp_thr = `PMICIRQ_MS_W'(`PMICIRQ_LP_16S_MS);
		endcase
		lp_hit = tick_r & ~db_lvl_r & edge_mode_r & system_on_i &
			(hold_ms_r == lp_thr) & (lp_state_r == pmicirq_pkg::LP_IDLE);
	end

	// Power-on and turn-off requests, one-cycle pulses.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_on_event_o <= 1'b0;
			turn_off_event_o <= 1'b0;
		end else begin
			if (edge_mode_r)
				power_on_event_o <= db_fall_r & ~system_on_i; // R12 R16
			else
				power_on_event_o <= db_rise_r & ~system_on_i; // R11
			turn_off_event_o <= (lp_hit & ~rst_en_r) | // R20
				(~edge_mode_r & db_fall_r & system_on_i); // R11
		end
	end

	// Long-press restart: power down, let supplies discharge, power up.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lp_state_r <= pmicirq_pkg::LP_IDLE;
			rs_cnt_r <= '0;
			power_down_req_o <= 1'b0;
			power_up_req_o <= 1'b0;
		end else begin
			power_down_req_o <= 1'b0;
			power_up_req_o <= 1'b0;
			unique case (lp_state_r)
				pmicirq_pkg::LP_IDLE: begin
					rs_cnt_r <= '0;
					if (lp_hit && rst_en_r) begin
						power_down_req_o <= 1'b1; // R19
						lp_state_r <= pmicirq_pkg::LP_DISCHARGE;
					end
				end
				pmicirq_pkg::LP_DISCHARGE: begin
					if (rs_cnt_r == RW'(RESTART_CYC - 1)) begin
						power_up_req_o <= 1'b1; // R19
						lp_state_r <= pmicirq_pkg::LP_IDLE;
					end else begin
						rs_cnt_r <= rs_cnt_r + 1'b1;
					end
				end
			endcase
		end
	end

	// Gather events and live conditions; bypassed faults still arrive.
	always_comb begin
		ev_all = evt_i.evt; // R23
		live_all = evt_i.live & LIVE_VALID; // R3 R10
		ev_all[`PMICIRQ_G_STATUS1][`PMICIRQ_BIT_EXT_IRQ] =
			evt_i.evt[`PMICIRQ_G_STATUS1][`PMICIRQ_BIT_EXT_IRQ] |
			(ext_d_r & ~ext_s2_r); // R22
		live_all[`PMICIRQ_G_STATUS1][`PMICIRQ_BIT_EXT_IRQ] = ext_s2_r;
		ev_all[`PMICIRQ_G_BUTTON] = {evt_i.evt[`PMICIRQ_G_BUTTON][7],
			hold_hit, db_rise_r & system_on_i, // R17
			db_fall_r}; // R16
		live_all[`PMICIRQ_G_BUTTON][`PMICIRQ_BIT_LIVE_BUTTON] =
			~btn_s2_r; // R13
	end

	// Write-one-to-clear strobes for each latch register.
	always_comb begin
		for (int g = 0; g < NG; g++) begin
			clr[g] = 8'h00;
			if (reg_req_i.wr && reg_req_i.addr ==
				8'(g * `PMICIRQ_GRP_STRIDE + `PMICIRQ_OFF_LATCH))
				clr[g] = reg_req_i.wdata; // R1
		end
	end

	// Latches: the set wins over a clear in the same cycle.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lat_r <= '0; // R24
		end else begin
			lat_r <= ((lat_r & ~clr) | ev_all) & VALID; // R1 R10
		end
	end

	// Mask registers; unimplemented bits stay zero from reset on.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_r <= {NG{MASK_RST}} & VALID;
		end else begin
			for (int g = 0; g < NG; g++) begin
				if (reg_req_i.wr && reg_req_i.addr ==
					8'(g * `PMICIRQ_GRP_STRIDE + `PMICIRQ_OFF_MASK))
					mask_r[g] <= reg_req_i.wdata & VALID[g*8 +: 8];
			end
		end
	end

	// Early warning has no group; it is cleared through the summary.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ewarn_r <= 1'b0;
		end else if (early_warning_i) begin
			ewarn_r <= 1'b1; // R8
		end else if (reg_req_i.wr &&
			reg_req_i.addr == `PMICIRQ_OFF_SUMMARY &&
			reg_req_i.wdata[`PMICIRQ_SUM_EWARN]) begin
			ewarn_r <= 1'b0;
		end
	end

	// Summary bits 0 to 6 follow the unmasked latches, so they clear by themselves.
	always_comb begin
		for (int g = 0; g < NG; g++)
			pend[g] = |(lat_r[g] & ~mask_r[g]); // R2
		sum_nxt[`PMICIRQ_SUM_STATUS1] = pend[`PMICIRQ_G_STATUS1]; // R5 R7
		sum_nxt[`PMICIRQ_SUM_STATUS2] = pend[`PMICIRQ_G_THERMAL];
		sum_nxt[`PMICIRQ_SUM_MODE] = pend[`PMICIRQ_G_MODE];
		sum_nxt[`PMICIRQ_SUM_ILIM] = pend[`PMICIRQ_G_SW_ILIM] |
			pend[`PMICIRQ_G_LDO_ILIM];
		sum_nxt[`PMICIRQ_SUM_UV] = pend[`PMICIRQ_G_SW_UV] |
			pend[`PMICIRQ_G_LDO_UV];
		sum_nxt[`PMICIRQ_SUM_OV] = pend[`PMICIRQ_G_SW_OV] |
			pend[`PMICIRQ_G_LDO_OV];
		sum_nxt[`PMICIRQ_SUM_BUTTON] = pend[`PMICIRQ_G_BUTTON]; // R6
		sum_nxt[`PMICIRQ_SUM_EWARN] = ewarn_r; // R8
	end

	// Summary and the open-drain output, low enable means pulling low.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sum_r <= 8'h00;
			irq_out_n_o <= 1'b0;
			irq_out_n_oe_n_o <= 1'b1;
		end else begin
			sum_r <= sum_nxt; // R6
			irq_out_n_o <= 1'b0;
			irq_out_n_oe_n_o <= ~|sum_nxt; // R4 R9
		end
	end

	// Read multiplexer; unmapped addresses read zero.
	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[`PMICIRQ_CTRL_RST_EN] = rst_en_r;
		ctrl_rd[`PMICIRQ_CTRL_DBNC_LO +: 2] = dbnc_sel_r;
		ctrl_rd[`PMICIRQ_CTRL_DELAY_LO +: 2] = delay_sel_r;
		ctrl_rd[`PMICIRQ_CTRL_EDGE] = edge_mode_r;
		rd_nxt = 8'h00;
		if (reg_req_i.addr == `PMICIRQ_OFF_SUMMARY)
			rd_nxt = sum_r;
		if (reg_req_i.addr == `PMICIRQ_OFF_CTRL)
			rd_nxt = ctrl_rd;
		for (int g = 0; g < NG; g++) begin
			if (reg_req_i.addr ==
				8'(g * `PMICIRQ_GRP_STRIDE + `PMICIRQ_OFF_LATCH))
				rd_nxt = lat_r[g];
			if (reg_req_i.addr ==
				8'(g * `PMICIRQ_GRP_STRIDE + `PMICIRQ_OFF_MASK))
				rd_nxt = mask_r[g];
			if (reg_req_i.addr ==
				8'(g * `PMICIRQ_GRP_STRIDE + `PMICIRQ_OFF_LIVE))
				rd_nxt = live_all[g];
		end
	end

	// Read data is captured on the read strobe and then held.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_req_i.rd)
			reg_rdata_o <= rd_nxt;
	end

endmodule // pmicirq_top

`default_nettype wire

//--- pmicirq_props.sv
// Port-level assertions for the interrupt aggregator and button block.
`timescale 1ns/1ps
`default_nettype none
`include "pmicirq_defs.svh"
module pmicirq_props #(
	parameter int TICK_CYCLES = 10,
	parameter logic [7:0] MASK_RST = 8'hFF
) (
	// Clock, reset and register port.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire pmicirq_pkg::pmicirq_reg_req_t reg_req_i,
	input wire logic [7:0] reg_rdata_o,
	// Events and outputs.
	input wire pmicirq_pkg::pmicirq_evt_t evt_i,
	input wire logic irq_out_n_o,
	input wire logic irq_out_n_oe_n_o,
	input wire logic power_on_event_o,
	input wire logic turn_off_event_o,
	input wire logic power_down_req_o,
	input wire logic power_up_req_o
);
	logic [9:0][7:0] mask_r;
	logic [11:0] gap_r;
	logic hit;

	// Shadow of the masks, rebuilt from the writes seen on the port.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_r <= {10{MASK_RST}};
		end else begin
			for (int g = 0; g < 10; g++) begin
				if (reg_req_i.wr && reg_req_i.addr == 8'(3 * g + 1)) begin
					mask_r[g] <= reg_req_i.wdata;
				end
			end
		end
	end

	// Cycles since the last power-down request; saturates to stay quiet.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_r <= 12'h000;
		end else if (power_down_req_o) begin
			gap_r <= 12'h001;
		end else if (gap_r != 12'h000 && gap_r != 12'hFFF) begin
			gap_r <= gap_r + 12'h001;
		end
	end

	// An event on an implemented bit whose mask is clear.
	assign hit = |(evt_i.evt & ~mask_r & `PMICIRQ_VALID);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_unmasked_evt;
		hit && !reg_req_i.wr;
	endsequence
	sequence s_line_release;
		$rose(irq_out_n_oe_n_o);
	endsequence

	a_unmasked_pulls: assert property (
		s_unmasked_evt |-> ##[2:3] !irq_out_n_oe_n_o)
		else $error("Unmasked event left the line high.");
	a_release_by_write: assert property (
		s_line_release |-> $past(reg_req_i.wr, 2) || $past(reg_req_i.wr, 3)
			|| $past(reg_req_i.wr, 4))
		else $error("Line released without a write.");
	a_open_drain_low: assert property (
		irq_out_n_o == 1'b0)
		else $error("Open-drain data not low.");
	a_read_data_holds: assert property (
		!reg_req_i.rd [*2] |=> $stable(reg_rdata_o))
		else $error("Read data moved without a read.");
	a_reset_line_idle: assert property (
		$rose(rst_n_i) |-> irq_out_n_oe_n_o && !power_up_req_o)
		else $error("Line or request active after reset.");
	a_power_on_single: assert property (
		power_on_event_o |=> !power_on_event_o)
		else $error("Power-on event longer than a cycle.");
	a_turn_off_alone: assert property (
		turn_off_event_o |-> !power_down_req_o ##1 !turn_off_event_o)
		else $error("Turn-off event malformed.");
	a_restart_gap: assert property (
		power_up_req_o |-> gap_r == 12'hBB8)
		else $error("Power-up not 30 us after power-down.");
endmodule // pmicirq_props

bind pmicirq_top pmicirq_props #(
	.TICK_CYCLES(TICK_CYCLES),
	.MASK_RST(MASK_RST)
) pmicirq_props_inst (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
	.reg_rdata_o(reg_rdata_o), .evt_i(evt_i), .irq_out_n_o(irq_out_n_o),
	.irq_out_n_oe_n_o(irq_out_n_oe_n_o), .power_on_event_o(power_on_event_o),
	.turn_off_event_o(turn_off_event_o), .power_down_req_o(power_down_req_o),
	.power_up_req_o(power_up_req_o)
);
`default_nettype wire

//--- pmicirq_host.sv
// Host model: drives the register port and services interrupts.
`timescale 1ns/1ps
`default_nettype none
module pmicirq_host (
	// Clock.
	input wire logic ref_clk_i,
	// Register port.
	output var pmicirq_pkg::pmicirq_reg_req_t reg_req_o,
	input wire logic [7:0] reg_rdata_i
);
	// Bus starts at zero; between accesses it shows the inverted address so a stale address is never reused.
	initial reg_req_o = '0;

	// One write strobe, then the bus is released.
	task automatic reg_write(input logic [7:0] a, d);
		@(posedge ref_clk_i);
		reg_req_o <= {2'b10, a, d};
		@(posedge ref_clk_i);
		reg_req_o <= {2'b00, ~a, ~d};
	endtask

	// Read strobe; data is taken once it has settled.
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_req_o <= {2'b01, a, 8'h00};
		@(posedge ref_clk_i);
		reg_req_o <= {2'b00, ~a, 8'hA5};
		@(posedge ref_clk_i);
		#1;
		d = reg_rdata_i;
	endtask

	// Summary first, then the latch of the group passed in as g, then write back its ones.
	task automatic service(input int g, gap, output logic [7:0] s, l);
		repeat (gap) @(posedge ref_clk_i);
		reg_read(8'h1E, s);
		reg_read(8'(3 * g), l);
		reg_write(8'(3 * g), l);
	endtask
endmodule // pmicirq_host
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the interrupt aggregator and button block.
`timescale 1ns/1ps
`default_nettype none
`include "pmicirq_defs.svh"
module testbench;
	localparam int TK = 2;
	localparam logic [7:0] SUM = 8'h1E;
	localparam logic [7:0] CTL = 8'h1F;
	localparam logic [7:0] BTN = 8'h1B;
	logic ref_clk_i, rst_n_i, ew, son, btn_n, ext_n, oe_n, on, off, dn, up;
	logic od;
	logic ecfg = 1'b1, rcfg = 1'b0;
	logic [1:0] dbd, dld;
	logic [7:0] rd, s, l, m, v, x;
	pmicirq_pkg::pmicirq_reg_req_t req;
	pmicirq_pkg::pmicirq_evt_t evt;
	int n_mismatch = 0, cmp_count = 0, seed = 12609;
	int n_on = 0, n_off = 0, n_dn = 0, n_up = 0, g, b, thr;
	int hold[5] = '{1000, 2000, 3000, 4000, 8000};
	time t0;

	// Free-running clock.
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Count the one-cycle power request pulses.
	always @(posedge ref_clk_i) begin
		n_on += (on === 1'b1);
		n_off += (off === 1'b1);
		n_dn += (dn === 1'b1);
		n_up += (up === 1'b1);
	end

	pmicirq_top #(.TICK_CYCLES(TK)) pmicirq_top_inst (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
		.reg_rdata_o(rd), .evt_i(evt), .early_warning_i(ew),
		.system_on_i(son), .power_button_in_i(btn_n),
		.external_irq_in_n_i(ext_n), .irq_out_n_o(od),
		.irq_out_n_oe_n_o(oe_n), .button_edge_mode_cfg_i(ecfg),
		.button_debounce_default_i(dbd), .long_press_delay_default_i(dld),
		.long_press_reset_default_i(rcfg), .power_on_event_o(on),
		.turn_off_event_o(off), .power_down_req_o(dn), .power_up_req_o(up)
	);
	pmicirq_host host (.ref_clk_i(ref_clk_i), .reg_req_o(req),
		.reg_rdata_i(rd));

	// Compare and count; a difference is reported at once.
	task automatic check(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, exp);
		logic [7:0] d;
		host.reg_read(a, d);
		check(d, exp);
	endtask
	// Wait until so many ms after the last button change.
	task automatic wait_ms(input int ms);
		while ($time < t0 + ms * TK * 10) @(posedge ref_clk_i);
	endtask
	function automatic logic [7:0] vb(input logic [79:0] c, input int g);
		return c[8 * g +: 8];
	endfunction
	function automatic logic [7:0] sbit(input int g);
		case (g)
			0, 1, 2: return 8'h01 << g;
			3, 4: return 8'h08;
			5, 7: return 8'h10;
			default: return 8'h20;
		endcase
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Cut a hang short well past the expected run length.
	initial begin
		#1000000;
		n_mismatch++;
		$display("MISMATCH %0t watchdog expired", $time);
		tally_and_finish();
	end

	// Reset, then the tests in order.
	initial begin
		dbd = 2'($random(seed));
		dld = 2'($random(seed));
		rst_n_i = 1'b0;
		evt = '0;
		ew = 1'b0;
		son = 1'b0;
		btn_n = 1'b1;
		ext_n = 1'b1;
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (g = 0; g < 10; g++) begin
			rchk(8'(3 * g), 8'h00);
			rchk(8'(3 * g + 1), vb(`PMICIRQ_VALID, g));
		end
		rchk(CTL, {3'b001, dld, dbd, 1'b0});
		host.reg_write(SUM, 8'h7F);
		rchk(SUM, 8'h00);
		host.reg_write(8'h40, 8'hFF);
		rchk(8'h40, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			g = $unsigned($random(seed)) % 9;
			v = vb(`PMICIRQ_VALID, g);
			b = $unsigned($random(seed)) % 8;
			while (!v[b])
				b = (b + 1) % 8;
			m = 8'($random(seed));
			host.reg_write(8'(3 * g + 1), m);
			@(posedge ref_clk_i);
			evt.evt[g][b] <= 1'b1;
			@(posedge ref_clk_i);
			evt.evt <= '0;
			repeat (3) @(posedge ref_clk_i);
			#1;
			check({7'h00, oe_n}, {7'h00, m[b]});
			host.service(g, $unsigned($random(seed)) % 3, s, l);
			check(s, m[b] ? 8'h00 : sbit(g));
			check(l, 8'h01 << b);
			rchk(SUM, 8'h00);
			check({7'h00, oe_n}, 8'h01);
		end
		$display("test events done");
		for (g = 1; g < 9; g++) begin
			@(posedge ref_clk_i);
			evt.live[g] <= 8'($random(seed));
			@(posedge ref_clk_i);
			rchk(8'(3 * g + 2), evt.live[g] & vb(`PMICIRQ_LIVE_VALID, g));
		end
		$display("test live done");
		host.reg_write(8'h01, 8'hFB);
		@(posedge ref_clk_i);
		ext_n <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		#1;
		check({7'h00, oe_n}, 8'h00);
		check({7'h00, od}, 8'h00);
		host.service(0, 0, s, l);
		check(s, 8'h01);
		check(l, 8'h04);
		host.reg_write(8'h01, 8'hFF);
		@(posedge ref_clk_i);
		ext_n <= 1'b1;
		ew <= 1'b1;
		@(posedge ref_clk_i);
		ew <= 1'b0;
		rchk(SUM, 8'h80);
		check({7'h00, oe_n}, 8'h00);
		host.reg_write(SUM, 8'h80);
		rchk(SUM, 8'h00);
		check({7'h00, oe_n}, 8'h01);
		$display("test pin and warning done");
		for (int c = 0; c < 4; c++) begin
			thr = c == 3 ? 750 : c == 2 ? 125 : 32;
			host.reg_write(CTL, 8'(c << 1));
			@(posedge ref_clk_i);
			son <= (c != 0);
			btn_n <= 1'b0;
			t0 = $time;
			wait_ms(thr - 4);
			rchk(BTN, 8'h00);
			wait_ms(thr + 4);
			rchk(BTN, 8'h01);
			rchk(BTN + 8'h02, 8'h01);
			@(posedge ref_clk_i);
			btn_n <= 1'b1;
			t0 = $time;
			wait_ms(36);
			rchk(BTN, c != 0 ? 8'h03 : 8'h01);
			host.reg_write(BTN, 8'hFF);
		end
		check(8'(n_on), 8'h01);
		$display("test debounce done");
		host.reg_write(CTL, 8'h00);
		@(posedge ref_clk_i);
		btn_n <= 1'b0;
		t0 = $time;
		x = 8'h01;
		for (int k = 0; k < 5; k++) begin
			wait_ms(36 + hold[k]);
			x |= 8'h04 << k;
			rchk(BTN, x);
			check(8'(n_off), 8'(k > 0));
		end
		check(8'(n_dn), 8'h00);
		@(posedge ref_clk_i);
		btn_n <= 1'b1;
		t0 = $time;
		wait_ms(40);
		host.reg_write(BTN, 8'hFF);
		$display("test hold done");
		host.reg_write(CTL, 8'h09);
		@(posedge ref_clk_i);
		btn_n <= 1'b0;
		t0 = $time;
		wait_ms(3990);
		check(8'(n_dn), 8'h00);
		wait_ms(4040);
		check(8'(n_dn), 8'h01);
		repeat (3010) @(posedge ref_clk_i);
		check(8'(n_up), 8'h01);
		rchk(CTL, {3'b001, dld, dbd, 1'b0});
		$display("test restart done");
		// Second reset with the level-sensitive strap and reset enable set.
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		ecfg <= 1'b0;
		rcfg <= 1'b1;
		son <= 1'b0;
		btn_n <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rchk(CTL, {3'b000, dld, dbd, 1'b1});
		host.reg_write(CTL, 8'h00);
		for (int k = 0; k < 3; k++) begin
			@(posedge ref_clk_i);
			son <= (k == 2);
			btn_n <= (k == 1);
			t0 = $time;
			wait_ms(40);
			check(8'(n_on), k > 0 ? 8'h02 : 8'h01);
			check(8'(n_off), k > 1 ? 8'h02 : 8'h01);
		end
		$display("test level mode done");
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
